// ---- src/error_code_unit.sv ----
// Contract
// - code zero only in operating mode with no fault of any group.
// - remote set-up reports 001, start-up and restore 003; weight invalid.
// - excitation short circuit or overload gives 010.
// - sense voltage low, unbalanced or reversed gives 011.
// - excessively high input from broken transducer connection gives 012.
// - signal out of range high gives 013, low gives 015.
// - weight errors held while the cause persists, cleared once removed.
// - start-up codes raised only during the start-up sequence.
// - set-up version mismatch gives 080 and loads default parameters.
// - bad parameter checksum gives 081 and loads default parameters.
// - corrupted factory range constant gives fatal code 083 to 085.
// - RAM failure gives fatal 097, flash failure gives fatal 098.
// - watchdog expiry reinitialises, reports 099, resumes only on reset command.
// - firmware kicks the watchdog; missing kicks trigger the watchdog error.
// - command not applicable in the current mode gives 100.
// - written value above maximum gives 101, below minimum gives 102.
// - float write with odd register count gives 104.
// - scaled integer decimal count of 8 or more gives 105.
// - enter set-up or restore not permitted in this mode gives 130.
// - exit set-up accepted only in remote set-up or restore, else 131.
// - any error drops in-process, relays off, analog output zero, code readable.
// - codes grouped by origin, zero always means no error.
`timescale 1ns/1ns
module error_code_unit #(
  parameter int WDOG_CYCLES = errcode_pkg::WDOG_CYCLES,
  parameter int ANA_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // start-up self test results
  input wire logic chk_valid,
  input wire logic setup_ver_bad,
  input wire logic setup_sum_bad,
  input wire logic factory_cal_bad,
  input wire logic [1:0] factory_cal_sel,
  input wire logic ram_bad,
  input wire logic flash_bad,
  // transducer front end fault pins
  input wire logic [errcode_pkg::WF_N-1:0] fault_pins,
  // firmware watchdog service
  input wire logic wdog_kick,
  // commands from the control unit
  input wire logic cmd_valid,
  input wire errcode_pkg::cmd_t cmd_op,
  input wire logic cmd_mode_ok,
  // register writes from the control unit
  input wire logic wr_valid,
  input wire logic wr_float,
  input wire logic wr_setup,
  input wire logic wr_scaled,
  input wire logic [15:0] wr_addr,
  input wire logic [7:0] wr_count,
  input wire logic [3:0] wr_decimals,
  input wire logic wr_above_max,
  input wire logic wr_below_min,
  // status word read
  input wire logic code_read,
  // process side requests
  input wire logic [1:0] relay_req,
  input wire logic [ANA_W-1:0] ana_value,
  // status and process outputs
  output logic [errcode_pkg::CODE_W-1:0] error_code,
  output errcode_pkg::state_t state,
  output logic weight_valid,
  output logic in_process,
  output logic [1:0] relay_out,
  output logic [ANA_W-1:0] ana_out,
  output logic load_defaults,
  output logic reinit,
  // answer to each command, or to a write in a cycle without a command
  output logic resp_valid,
  output logic [errcode_pkg::CODE_W-1:0] resp_code
);

  logic [errcode_pkg::WF_N-1:0] weight_fault;
  logic wdog_run;
  logic wdog_expire;
  logic chk_fatal;
  logic [7:0] startup_code;
  logic [7:0] cmd_code;
  logic [7:0] wr_code;
  logic [7:0] new_event;
  logic [7:0] event_code;
  logic [7:0] fatal_code;
  logic [7:0] next_code;
  logic [7:0] weight_code;
  logic in_startup;
  logic cmd_reset_seen;

  pin_sync3 #(
    .W(errcode_pkg::WF_N)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(fault_pins),
    .level(weight_fault)
  );

  // timer halts once stopped in watchdog or fatal state
  assign wdog_run = (state != errcode_pkg::st_wdog) && (state != errcode_pkg::st_fatal);

  wdog_timer #(
    .CYCLES(WDOG_CYCLES)
  ) u_wdog (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(wdog_run),
    .kick(wdog_kick),
    .expire(wdog_expire)
  );

  assign in_startup = (state == errcode_pkg::st_startup);
  assign cmd_reset_seen = cmd_valid && (cmd_op == errcode_pkg::cmd_reset);

  // start-up self test classification, fatal faults first
  always_comb begin
    chk_fatal = ram_bad || flash_bad || factory_cal_bad;
    if (ram_bad) startup_code = errcode_pkg::E_RAM;
    else if (flash_bad) startup_code = errcode_pkg::E_FLASH;
    else if (factory_cal_bad && factory_cal_sel > errcode_pkg::FACTORY_SEL_MAX)
      startup_code = errcode_pkg::E_FACTORY_BASE + {6'h00, errcode_pkg::FACTORY_SEL_MAX};
    else if (factory_cal_bad) startup_code = errcode_pkg::E_FACTORY_BASE + {6'h00, factory_cal_sel};
    else if (setup_sum_bad) startup_code = errcode_pkg::E_SETUP_SUM;
    else if (setup_ver_bad) startup_code = errcode_pkg::E_SETUP_VER;
    else startup_code = errcode_pkg::E_NONE;
  end

  // command checking against the present mode
  always_comb begin
    cmd_code = errcode_pkg::E_NONE;
    case (cmd_op)
      errcode_pkg::cmd_enter_setup, errcode_pkg::cmd_enter_restore:
        if (state != errcode_pkg::st_oper) cmd_code = errcode_pkg::E_ENTER_DENIED;
      errcode_pkg::cmd_exit_setup:
        if (state != errcode_pkg::st_setup && state != errcode_pkg::st_restore)
          cmd_code = errcode_pkg::E_EXIT_DENIED;
      errcode_pkg::cmd_reset: cmd_code = errcode_pkg::E_NONE;
      default: if (!cmd_mode_ok) cmd_code = errcode_pkg::E_WRONG_STATE;
    endcase
  end

  // write checking, format faults before range faults
  always_comb begin
    if (wr_setup && state != errcode_pkg::st_setup) wr_code = errcode_pkg::E_WRONG_STATE;
    else if ((wr_float || wr_setup) && wr_addr[0]) wr_code = errcode_pkg::E_ODD_ADDR;
    else if (wr_float && wr_count[0]) wr_code = errcode_pkg::E_ODD_COUNT;
    else if (wr_scaled && wr_decimals >= errcode_pkg::DECIMALS_LIMIT) wr_code = errcode_pkg::E_DECIMALS;
    else if (wr_above_max) wr_code = errcode_pkg::E_ENTRY_HIGH;
    else if (wr_below_min) wr_code = errcode_pkg::E_ENTRY_LOW;
    else wr_code = errcode_pkg::E_NONE;
  end

  // event raised this cycle; start-up result outranks a request answer
  always_comb begin
    if (in_startup && chk_valid && !chk_fatal && startup_code != errcode_pkg::E_NONE) new_event = startup_code;
    else if (cmd_valid) new_event = cmd_code;
    else if (wr_valid) new_event = wr_code;
    else new_event = errcode_pkg::E_NONE;
  end

  // operating mode state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= errcode_pkg::st_startup;
    end else if (wdog_expire) begin
      state <= errcode_pkg::st_wdog;
    end else begin
      case (state)
        errcode_pkg::st_startup: begin
          if (chk_valid) state <= chk_fatal ? errcode_pkg::st_fatal : errcode_pkg::st_oper;
        end
        errcode_pkg::st_oper: begin
          if (cmd_valid && cmd_op == errcode_pkg::cmd_enter_setup) begin
            state <= errcode_pkg::st_setup;
          end else if (cmd_valid && cmd_op == errcode_pkg::cmd_enter_restore) begin
            state <= errcode_pkg::st_restore;
          end else if (cmd_reset_seen) begin
            state <= errcode_pkg::st_startup;
          end
        end
        errcode_pkg::st_setup, errcode_pkg::st_restore: begin
          if (cmd_valid && (cmd_op == errcode_pkg::cmd_exit_setup || cmd_op == errcode_pkg::cmd_reset)) begin
            state <= errcode_pkg::st_startup;
          end
        end
        errcode_pkg::st_wdog: begin
          if (cmd_reset_seen) state <= errcode_pkg::st_startup;
        end
        errcode_pkg::st_fatal: state <= errcode_pkg::st_fatal;
        default: begin
          state <= errcode_pkg::st_startup;
        end
      endcase
    end
  end

  // fatal start-up code, kept until the next rst_n reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) fatal_code <= errcode_pkg::E_NONE;
    else if (in_startup && chk_valid && chk_fatal) fatal_code <= startup_code;
  end

  // latest event stays until read; a new event wins over the read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) event_code <= errcode_pkg::E_NONE;
    else if (new_event != errcode_pkg::E_NONE) event_code <= new_event;
    else if (code_read) event_code <= errcode_pkg::E_NONE;
  end

  // weight fault priority, each held only while its pin is active
  always_comb begin
    if (weight_fault[errcode_pkg::WF_EXC]) weight_code = errcode_pkg::E_EXC_SHORT;
    else if (weight_fault[errcode_pkg::WF_SENSE]) weight_code = errcode_pkg::E_SENSE;
    else if (weight_fault[errcode_pkg::WF_BROKEN]) weight_code = errcode_pkg::E_SIG_BROKEN;
    else if (weight_fault[errcode_pkg::WF_HIGH]) weight_code = errcode_pkg::E_SIG_HIGH;
    else if (weight_fault[errcode_pkg::WF_LOW]) weight_code = errcode_pkg::E_SIG_LOW;
    else if (weight_fault[errcode_pkg::WF_OVER]) weight_code = errcode_pkg::E_OVERRANGE;
    else if (weight_fault[errcode_pkg::WF_UNDER]) weight_code = errcode_pkg::E_UNDERRANGE;
    else weight_code = errcode_pkg::E_NONE;
  end

  // status word selection by mode
  always_comb begin
    case (state)
      errcode_pkg::st_oper: begin
        if (weight_code != errcode_pkg::E_NONE) begin
          next_code = weight_code;
        end else begin
          next_code = event_code;
        end
      end
      errcode_pkg::st_setup: next_code = errcode_pkg::E_REMOTE_SETUP;
      errcode_pkg::st_fatal: next_code = fatal_code;
      errcode_pkg::st_wdog: next_code = errcode_pkg::E_WATCHDOG;
      default: next_code = errcode_pkg::E_NOT_NORMAL;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      error_code <= errcode_pkg::E_NOT_NORMAL;
      weight_valid <= 1'h0;
    end else begin
      error_code <= next_code;
      weight_valid <= (state == errcode_pkg::st_oper) && (weight_code == errcode_pkg::E_NONE);
    end
  end

  // process outputs forced safe while any code is shown
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_process <= 1'h0;
      relay_out <= 2'h0;
      ana_out <= '0;
    end else if (next_code != errcode_pkg::E_NONE) begin
      in_process <= 1'h0;
      relay_out <= 2'h0;
      ana_out <= '0;
    end else begin
      in_process <= 1'h1;
      relay_out <= relay_req;
      ana_out <= ana_value;
    end
  end

  // start-up side effects and watchdog reinitialise pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_defaults <= 1'h0;
      reinit <= 1'h0;
    end else begin
      load_defaults <= in_startup && chk_valid && !chk_fatal && !wdog_expire
                       && (setup_sum_bad || setup_ver_bad);
      reinit <= wdog_expire;
    end
  end

  // one answer per cycle with a request, command taking precedence
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'h0;
      resp_code <= errcode_pkg::E_NONE;
    end else begin
      resp_valid <= cmd_valid || wr_valid;
      resp_code <= cmd_valid ? cmd_code : (wr_valid ? wr_code : errcode_pkg::E_NONE);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_sum_fail;
    in_startup && chk_valid && setup_sum_bad && !chk_fatal && !wdog_expire;
  endsequence

  sequence s_wdog_reinit;
    state == errcode_pkg::st_wdog && reinit;
  endsequence

  a_zero_only_oper: assert property (
    error_code == errcode_pkg::E_NONE |-> $past(state) == errcode_pkg::st_oper)
    else $error("code zero outside operating mode");

  a_setup_code: assert property (
    state == errcode_pkg::st_setup && !wdog_expire |=> error_code == errcode_pkg::E_REMOTE_SETUP && !weight_valid)
    else $error("remote set-up not reported as 001");

  a_exc_short: assert property (
    state == errcode_pkg::st_oper && weight_fault[errcode_pkg::WF_EXC] |=> error_code == errcode_pkg::E_EXC_SHORT)
    else $error("excitation fault not reported");

  a_weight_clear: assert property (
    state == errcode_pkg::st_oper && weight_fault == '0 && event_code == errcode_pkg::E_NONE
    |=> error_code == errcode_pkg::E_NONE)
    else $error("weight code kept after cause removed");

  a_defaults_load: assert property (
    s_sum_fail |=> load_defaults && event_code == errcode_pkg::E_SETUP_SUM && state == errcode_pkg::st_oper)
    else $error("checksum failure did not load defaults");

  a_startup_scope: assert property (
    load_defaults |-> $past(state) == errcode_pkg::st_startup)
    else $error("defaults loaded outside start-up");

  a_fatal_hold: assert property (
    state == errcode_pkg::st_fatal |=> state == errcode_pkg::st_fatal && error_code == fatal_code)
    else $error("fatal state left or code lost");

  a_wdog_code: assert property (
    wdog_expire |=> s_wdog_reinit ##1 error_code == errcode_pkg::E_WATCHDOG)
    else $error("watchdog expiry not reported as 099");

  a_wdog_stay: assert property (
    state == errcode_pkg::st_wdog && !cmd_reset_seen |=> state == errcode_pkg::st_wdog)
    else $error("watchdog state left without reset command");

  a_exit_denied: assert property (
    cmd_valid && cmd_op == errcode_pkg::cmd_exit_setup && state == errcode_pkg::st_oper
    |=> resp_valid && resp_code == errcode_pkg::E_EXIT_DENIED)
    else $error("exit outside set-up not refused with 131");

  a_odd_addr: assert property (
    !cmd_valid && wr_valid && wr_float && wr_addr[0] |=> resp_code == errcode_pkg::E_ODD_ADDR)
    else $error("odd float start address not refused");

  a_decimals: assert property (
    !cmd_valid && wr_valid && wr_scaled && !wr_float && !wr_setup && wr_decimals >= errcode_pkg::DECIMALS_LIMIT
    |=> resp_code == errcode_pkg::E_DECIMALS)
    else $error("scaled decimal count not refused");

  a_outputs_safe: assert property (
    error_code != errcode_pkg::E_NONE |-> !in_process && relay_out == 2'h0 && ana_out == '0)
    else $error("process outputs active during error");

endmodule // error_code_unit

// ---- src/errcode_pkg.sv ----
package errcode_pkg;

  localparam int CODE_W = 8;

  // reported codes, value equals the decimal code
  localparam logic [7:0] E_NONE = 8'h00;
  localparam logic [7:0] E_REMOTE_SETUP = 8'h01;
  localparam logic [7:0] E_NOT_NORMAL = 8'h03;
  localparam logic [7:0] E_OVERRANGE = 8'h05;
  localparam logic [7:0] E_UNDERRANGE = 8'h07;
  localparam logic [7:0] E_EXC_SHORT = 8'h0A;
  localparam logic [7:0] E_SENSE = 8'h0B;
  localparam logic [7:0] E_SIG_BROKEN = 8'h0C;
  localparam logic [7:0] E_SIG_HIGH = 8'h0D;
  localparam logic [7:0] E_SIG_LOW = 8'h0F;
  localparam logic [7:0] E_SETUP_VER = 8'h50;
  localparam logic [7:0] E_SETUP_SUM = 8'h51;
  localparam logic [7:0] E_FACTORY_BASE = 8'h53;
  localparam logic [7:0] E_RAM = 8'h61;
  localparam logic [7:0] E_FLASH = 8'h62;
  localparam logic [7:0] E_WATCHDOG = 8'h63;
  localparam logic [7:0] E_WRONG_STATE = 8'h64;
  localparam logic [7:0] E_ENTRY_HIGH = 8'h65;
  localparam logic [7:0] E_ENTRY_LOW = 8'h66;
  localparam logic [7:0] E_ODD_ADDR = 8'h67;
  localparam logic [7:0] E_ODD_COUNT = 8'h68;
  localparam logic [7:0] E_DECIMALS = 8'h69;
  localparam logic [7:0] E_ENTER_DENIED = 8'h82;
  localparam logic [7:0] E_EXIT_DENIED = 8'h83;

  // factory calibration sub code selects 083..085
  localparam logic [1:0] FACTORY_SEL_MAX = 2'h2;
  localparam logic [3:0] DECIMALS_LIMIT = 4'h8;

  // weight fault pin positions
  localparam int WF_EXC = 0;
  localparam int WF_SENSE = 1;
  localparam int WF_BROKEN = 2;
  localparam int WF_HIGH = 3;
  localparam int WF_LOW = 4;
  localparam int WF_OVER = 5;
  localparam int WF_UNDER = 6;
  localparam int WF_N = 7;

  localparam int CLK_MHZ = 25;
  localparam int WDOG_TIMEOUT_US = 100;
  localparam int WDOG_CYCLES = WDOG_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    st_startup,
    st_oper,
    st_setup,
    st_restore,
    st_fatal,
    st_wdog
  } state_t;

  typedef enum logic [2:0] {
    cmd_other,
    cmd_enter_setup,
    cmd_enter_restore,
    cmd_exit_setup,
    cmd_reset
  } cmd_t;

endpackage

// ---- src/pin_sync3.sv ----
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // asynchronous pins and filtered level
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit changes only once second and third stage agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s2[i];
        end
      end
    end
  end

endmodule // pin_sync3

// ---- src/wdog_timer.sv ----
`timescale 1ns/1ns
module wdog_timer #(
  parameter int CYCLES = 2500
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic kick,
  // expiry pulse
  output logic expire
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // missing service pulses let the count reach the limit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      expire <= 1'h0;
    end else if (!run || kick) begin
      count <= '0;
      expire <= 1'h0;
    end else if (count == LAST) begin
      count <= '0;
      expire <= 1'h1;
    end else begin
      count <= count + CW'(1);
      expire <= 1'h0;
    end
  end

endmodule // wdog_timer

// ---- tb/control_unit_model.sv ----
`timescale 1ns/1ns
module control_unit_model (
  // clock
  input wire logic clk_sys,
  // command strobe
  output logic cmd_valid,
  output errcode_pkg::cmd_t cmd_op,
  output logic cmd_mode_ok,
  // register write
  output logic wr_valid,
  output logic wr_float,
  output logic wr_setup,
  output logic wr_scaled,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_count,
  output logic [3:0] wr_decimals,
  output logic wr_above_max,
  output logic wr_below_min,
  // status word read
  output logic code_read
);
  initial begin
    {cmd_valid, cmd_mode_ok, wr_valid, wr_float, wr_setup, wr_scaled, code_read} = 7'h00;
    {wr_addr, wr_count, wr_decimals, wr_above_max, wr_below_min} = 30'h0;
    cmd_op = errcode_pkg::cmd_other;
  end

  task automatic send_cmd(input errcode_pkg::cmd_t op, input logic ok);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_mode_ok <= ok;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_mode_ok <= ~ok;
  endtask

  // odd address or odd count while wr_valid is high only when the bench asks; afterwards wr_addr and wr_count are inverted
  task automatic send_wr(input logic [2:0] kind, input logic [15:0] a, input logic [7:0] n,
                         input logic [3:0] d, input logic [1:0] rng);
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    {wr_float, wr_setup, wr_scaled} <= kind;
    wr_addr <= a;
    wr_count <= n;
    wr_decimals <= d;
    {wr_above_max, wr_below_min} <= rng;
    @(posedge clk_sys);
    wr_valid <= 1'b0;
    wr_addr <= ~a;
    wr_count <= ~n;
  endtask

  task automatic read_code;
    @(posedge clk_sys);
    code_read <= 1'b1;
    @(posedge clk_sys);
    code_read <= 1'b0;
  endtask
endmodule // control_unit_model

// ---- tb/instrument_error_code_unit_tb.sv ----
`timescale 1ns/1ns
module instrument_error_code_unit_tb;
  localparam int WD = 20;
  logic clk_sys, rst_n, chk_valid, setup_ver_bad, setup_sum_bad, factory_cal_bad, ram_bad, flash_bad;
  logic wdog_kick, cmd_valid, cmd_mode_ok, wr_valid, wr_float, wr_setup, wr_scaled, wr_above_max;
  logic wr_below_min, code_read, weight_valid, in_process, load_defaults, reinit, resp_valid, kick_en;
  logic [1:0] factory_cal_sel, relay_req, relay_out;
  logic [6:0] fault_pins;
  logic [15:0] ana_value, ana_out, wr_addr;
  logic [7:0] wr_count, error_code, resp_code;
  logic [3:0] wr_decimals;
  errcode_pkg::cmd_t cmd_op;
  errcode_pkg::state_t state;
  logic [7:0] exp_q[$];
  logic [7:0] wcode[7] = '{errcode_pkg::E_EXC_SHORT, errcode_pkg::E_SENSE, errcode_pkg::E_SIG_BROKEN,
    errcode_pkg::E_SIG_HIGH, errcode_pkg::E_SIG_LOW, errcode_pkg::E_OVERRANGE, errcode_pkg::E_UNDERRANGE};
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_reinit = 0;
  int seed = 32'h71FDA5E9;

  error_code_unit #(.WDOG_CYCLES(WD)) dut (.clk_sys, .rst_n, .chk_valid, .setup_ver_bad, .setup_sum_bad,
    .factory_cal_bad, .factory_cal_sel, .ram_bad, .flash_bad, .fault_pins, .wdog_kick, .cmd_valid, .cmd_op,
    .cmd_mode_ok, .wr_valid, .wr_float, .wr_setup, .wr_scaled, .wr_addr, .wr_count, .wr_decimals,
    .wr_above_max, .wr_below_min, .code_read, .relay_req, .ana_value, .error_code, .state, .weight_valid,
    .in_process, .relay_out, .ana_out, .load_defaults, .reinit, .resp_valid, .resp_code);
  control_unit_model cu (.clk_sys, .cmd_valid, .cmd_op, .cmd_mode_ok, .wr_valid, .wr_float, .wr_setup,
    .wr_scaled, .wr_addr, .wr_count, .wr_decimals, .wr_above_max, .wr_below_min, .code_read);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  function automatic logic [15:0] ev();
    return 16'($random(seed)) & 16'hFFFE;
  endfunction

  task automatic do_cmd(input errcode_pkg::cmd_t op, input logic ok, input logic [7:0] e);
    exp_q.push_back(e);
    cu.send_cmd(op, ok);
  endtask

  task automatic do_wr(input logic [2:0] k, input logic [15:0] a, input logic [7:0] n, input logic [3:0] d,
                       input logic [1:0] r, input logic [7:0] e);
    exp_q.push_back(e);
    cu.send_wr(k, a, n, d, r);
  endtask

  // b = {ram, flash, factory, checksum, version}
  task automatic startup(input logic [4:0] b, input logic [7:0] e);
    @(posedge clk_sys);
    chk_valid <= 1'b1;
    {ram_bad, flash_bad, factory_cal_bad, setup_sum_bad, setup_ver_bad} <= b;
    @(posedge clk_sys);
    chk_valid <= 1'b0;
    wait_n(1);
    chk("load_defaults", 16'(b[4:2] == 3'h0 && b[1:0] != 2'h0), 16'(load_defaults));
    wait_n(1);
    chk("error_code", 16'(e), 16'(error_code));
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    wdog_kick <= kick_en && cyc % 8 == 0;
    if (reinit === 1'b1) n_reinit++;
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("resp_extra", 16'h0000, 16'h0001);
      else chk("resp_code", 16'(exp_q.pop_front()), 16'(resp_code));
    end
    if (cyc > 5000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    {rst_n, chk_valid, setup_ver_bad, setup_sum_bad, factory_cal_bad, ram_bad, flash_bad} = 7'h00;
    {factory_cal_sel, relay_req, fault_pins, ana_value} = 27'h0;
    kick_en = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_n(1);
    chk("error_code", 16'(errcode_pkg::E_NOT_NORMAL), 16'(error_code));
    chk("state", 16'(errcode_pkg::st_startup), 16'(state));
    startup(5'h02, errcode_pkg::E_SETUP_SUM);
    cu.read_code();
    ana_value <= 16'($random(seed));
    relay_req <= 2'($random(seed));
    wait_n(4);
    chk("error_code", 16'(errcode_pkg::E_NONE), 16'(error_code));
    chk("ana_out", ana_value, ana_out);
    chk("relay_out", 16'(relay_req), 16'(relay_out));
    chk("in_process", 16'h0001, 16'(in_process));
    chk("weight_valid", 16'h0001, 16'(weight_valid));
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      fault_pins <= 7'(1 << i);
      wait_n(8);
      chk("error_code", 16'(wcode[i]), 16'(error_code));
      chk("dropped", 16'h0000, {ana_out[13:0], relay_out} | 16'({weight_valid, in_process}));
      @(posedge clk_sys);
      fault_pins <= 7'h00;
      wait_n(8);
      chk("error_code", 16'(errcode_pkg::E_NONE), 16'(error_code));
    end
    do_wr(3'h4, 16'h0001, 8'h02, 4'h0, 2'h0, errcode_pkg::E_ODD_ADDR);
    do_wr(3'h4, ev(), 8'h03, 4'h0, 2'h0, errcode_pkg::E_ODD_COUNT);
    do_wr(3'h1, ev(), 8'h02, 4'h8, 2'h0, errcode_pkg::E_DECIMALS);
    do_wr(3'h1, ev(), 8'h03, 4'h7, 2'h0, errcode_pkg::E_NONE);
    do_wr(3'h2, ev(), 8'h02, 4'h0, 2'h0, errcode_pkg::E_WRONG_STATE);
    do_wr(3'h4, ev(), 8'h02, 4'h0, 2'h2, errcode_pkg::E_ENTRY_HIGH);
    do_wr(3'h4, ev(), 8'h02, 4'h0, 2'h1, errcode_pkg::E_ENTRY_LOW);
    wait_n(3);
    chk("error_code", 16'(errcode_pkg::E_ENTRY_LOW), 16'(error_code));
    do_wr(3'h4, ev(), 8'h02, 4'h0, 2'h0, errcode_pkg::E_NONE);
    do_cmd(errcode_pkg::cmd_other, 1'b0, errcode_pkg::E_WRONG_STATE);
    do_cmd(errcode_pkg::cmd_other, 1'b1, errcode_pkg::E_NONE);
    do_cmd(errcode_pkg::cmd_exit_setup, 1'b1, errcode_pkg::E_EXIT_DENIED);
    do_cmd(errcode_pkg::cmd_enter_setup, 1'b1, errcode_pkg::E_NONE);
    wait_n(3);
    chk("error_code", 16'(errcode_pkg::E_REMOTE_SETUP), 16'(error_code));
    chk("weight_valid", 16'h0000, 16'(weight_valid));
    do_wr(3'h2, 16'h0003, 8'h02, 4'h0, 2'h0, errcode_pkg::E_ODD_ADDR);
    do_wr(3'h2, ev(), 8'h01, 4'h0, 2'h0, errcode_pkg::E_NONE);
    do_cmd(errcode_pkg::cmd_enter_restore, 1'b1, errcode_pkg::E_ENTER_DENIED);
    do_cmd(errcode_pkg::cmd_exit_setup, 1'b1, errcode_pkg::E_NONE);
    cu.read_code();
    startup(5'h01, errcode_pkg::E_SETUP_VER);
    cu.read_code();
    do_cmd(errcode_pkg::cmd_enter_restore, 1'b1, errcode_pkg::E_NONE);
    wait_n(3);
    chk("error_code", 16'(errcode_pkg::E_NOT_NORMAL), 16'(error_code));
    do_cmd(errcode_pkg::cmd_exit_setup, 1'b1, errcode_pkg::E_NONE);
    startup(5'h00, errcode_pkg::E_NONE);
    kick_en <= 1'b0;
    wait_n(WD + 8);
    chk("state", 16'(errcode_pkg::st_wdog), 16'(state));
    chk("error_code", 16'(errcode_pkg::E_WATCHDOG), 16'(error_code));
    chk("reinit_count", 16'h0001, 16'(n_reinit));
    kick_en <= 1'b1;
    do_cmd(errcode_pkg::cmd_reset, 1'b1, errcode_pkg::E_NONE);
    wait_n(2);
    chk("state", 16'(errcode_pkg::st_startup), 16'(state));
    for (int k = 0; k < 6; k++) begin
      do_reset();
      factory_cal_sel <= 2'(k);
      startup(k < 4 ? 5'h04 : (k == 4 ? 5'h1F : 5'h0C), k < 4 ? errcode_pkg::E_FACTORY_BASE + 8'(k > 2 ? 2 : k)
        : (k == 4 ? errcode_pkg::E_RAM : errcode_pkg::E_FLASH));
      wait_n(4);
      chk("state", 16'(errcode_pkg::st_fatal), 16'(state));
    end
    wait_n(3);
    chk("resp_pending", 16'h0000, 16'(exp_q.size()));
    end_sim();
  end
endmodule // instrument_error_code_unit_tb
